// ===== core/rmsc_config.sv
// Modem preamble/deviation and radio state machine configuration bank with serial port
// Function
// - Preamble code 0..7 selects 2,3,4,6,8,12,16,24 bytes; reset code 2.
// - Deviation exponent bits 6:4 reset 4, mantissa 2:0 reset 7, implied one.
// - Deviation equals crystal over 2^17 times (8+mantissa) times 2^exponent.
// - FSK transmit shifts carrier down for zero symbol, up for one.
// - FSK receive uses programmed deviation as expected incoming deviation.
// - OOK ignores deviation exponent and mantissa in receive and transmit.
// - RSSI termination bit ends reception on loss of carrier sense; resets zero.
// - With RSSI termination and OOK, leave receive if no carrier in eight symbols.
// - Clear-channel mode: always, RSSI low, not receiving, or both; reset 3.
// - Clear-channel output follows the condition chosen by the mode field.
// - After reception go idle, synth-ready, transmit or stay receive; reset 0.
// - After transmission go idle, synth-ready, stay transmit, or receive; reset 0.
// - Modulation codes: 0 2-FSK, 1 GFSK, 3 OOK, 4 4-FSK; others reserved.
`timescale 1ns/1ps
module rmsc_config
    import rmsc_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           reset,
    input  wire rmsc_spi_in_s   spiIn,
    output logic                spiMiso,
    input  wire logic [2:0]     modFormat,
    input  wire rmsc_radio_in_s radioIn,
    output rmsc_radio_e         radioState,
    output logic                clearChannel,
    output logic [4:0]          preambleBytes,
    output logic [10:0]         devWord,
    output logic [11:0]         txOffset,
    output logic [10:0]         rxExpectedDev
);
    rmsc_state_s st;
    rmsc_state_s next_st;

    function automatic logic [4:0] preamble_len(input logic [2:0] code);
        case (code)
            3'h0:    preamble_len = 5'h02;
            3'h1:    preamble_len = 5'h03;
            3'h2:    preamble_len = 5'h04;
            3'h3:    preamble_len = 5'h06;
            3'h4:    preamble_len = 5'h08;
            3'h5:    preamble_len = 5'h0C;
            3'h6:    preamble_len = 5'h10;
            default: preamble_len = 5'h18;
        endcase
    endfunction : preamble_len

    function automatic rmsc_radio_e after_state(input logic [1:0] code, input logic fromRx);
        case (code)
            2'h0:    after_state = RMSC_IDLE;
            2'h1:    after_state = RMSC_FSTXR;
            2'h2:    after_state = fromRx ? RMSC_TX : RMSC_TX;
            default: after_state = fromRx ? RMSC_RX : RMSC_RX;
        endcase
    endfunction : after_state

    logic       isFsk;
    logic       isOok;
    logic [2:0] devExp;
    logic [2:0] devMant;
    logic [1:0] ccaMode;
    logic       sclkRise;
    logic       sclkFall;
    logic [7:0] hdrByte;
    logic [7:0] readData;
    logic       rxTerminate;

    always_comb begin
        isFsk   = (modFormat == MOD_2FSK) || (modFormat == MOD_GFSK) || (modFormat == MOD_4FSK);
        isOok   = (modFormat == MOD_OOK);
        devExp  = st.deviation[DEV_EXP_LSB +: 3];
        devMant = st.deviation[DEV_MANT_LSB +: 3];
        ccaMode = st.nextStateCfg[CLEAR_CHANNEL_MODE_LSB +: 2];
        sclkRise = !spiIn.csN && spiIn.sclk && !st.sclkPrev;
        sclkFall = !spiIn.csN && !spiIn.sclk && st.sclkPrev;
        hdrByte  = {st.shiftIn[6:0], spiIn.mosi};
        if (hdrByte[5:0] == ADDR_PREAMBLE) begin
            readData = st.preambleCfg;
        end else if (hdrByte[5:0] == ADDR_DEVIATION) begin
            readData = st.deviation;
        end else if (hdrByte[5:0] == ADDR_RX_TIMEOUT) begin
            readData = st.rxTimeoutCfg;
        end else if (hdrByte[5:0] == ADDR_NEXT_STATE) begin
            readData = st.nextStateCfg;
        end else begin
            readData = 8'h00;
        end

        next_st = st;
        next_st.sclkPrev = spiIn.sclk;

        // Serial port: header byte then one data byte; burst bytes are ignored
        if (spiIn.csN) begin
            next_st.bitCount = 5'h00;
            next_st.shiftOut = 8'h00;
            next_st.miso     = 1'b0; // Aborted frame leaves no stale bit
        end else if (sclkRise && st.bitCount < SPI_FRAME_BITS) begin
            next_st.shiftIn  = hdrByte;
            next_st.bitCount = st.bitCount + 5'h01;
            if (st.bitCount == SPI_HEADER_BITS - 5'h01) begin
                next_st.isRead   = hdrByte[SPI_READ_BIT];
                next_st.addr     = hdrByte[5:0];
                next_st.shiftOut = readData;
            end else if (st.bitCount == SPI_FRAME_BITS - 5'h01 && !st.isRead) begin
                // Masked writes keep unused bits at zero
                if (st.addr == ADDR_PREAMBLE) begin
                    next_st.preambleCfg = hdrByte & WMASK_PREAMBLE;
                end else if (st.addr == ADDR_DEVIATION) begin
                    next_st.deviation = hdrByte & WMASK_DEVIATION;
                end else if (st.addr == ADDR_RX_TIMEOUT) begin
                    next_st.rxTimeoutCfg = hdrByte & WMASK_RX_TIMEOUT;
                end else if (st.addr == ADDR_NEXT_STATE) begin
                    next_st.nextStateCfg = hdrByte & WMASK_NEXT_STATE;
                end
            end
        end else if (sclkFall) begin
            next_st.miso     = st.shiftOut[7];
            next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
        end

        // Carrier-sense termination: FSK ends at once, OOK after eight silent symbols
        rxTerminate = 1'b0;
        if (st.radio == RMSC_RX && st.rxTimeoutCfg[RSSI_TERM_BIT] && !radioIn.receivingPacket) begin
            if (isOok) begin
                rxTerminate = !st.csSeen && !radioIn.carrierSense && radioIn.symbolTick
                              && st.symbolCount == OOK_TIMEOUT_SYMBOLS - 4'h1;
            end else begin
                rxTerminate = !radioIn.carrierSense;
            end
        end

        if (st.radio == RMSC_RX) begin
            if (radioIn.carrierSense) begin
                next_st.csSeen = 1'b1;
            end
            if (radioIn.symbolTick && st.symbolCount != OOK_TIMEOUT_SYMBOLS) begin
                next_st.symbolCount = st.symbolCount + 4'h1;
            end
        end else begin
            next_st.csSeen      = 1'b0;
            next_st.symbolCount = 4'h0;
        end

        // Idle request outranks packet completion, which outranks start strobes
        if (radioIn.goIdle) begin
            next_st.radio = RMSC_IDLE;
        end else begin
            case (st.radio)
                RMSC_RX: begin
                    if (radioIn.rxPacketDone) begin
                        next_st.radio = after_state(st.nextStateCfg[AFTER_RX_LSB +: 2], 1'b1);
                    end else if (rxTerminate) begin
                        next_st.radio = RMSC_IDLE;
                    end
                end
                RMSC_TX: begin
                    if (radioIn.txPacketDone) begin
                        // Code 2 keeps the transmitter on, sending preamble
                        next_st.radio = after_state(st.nextStateCfg[AFTER_TX_LSB +: 2], 1'b0);
                    end
                end
                default: begin
                    if (radioIn.startTx) begin
                        next_st.radio = RMSC_TX;
                    end else if (radioIn.startRx) begin
                        next_st.radio = RMSC_RX;
                    end
                end
            endcase
        end
        if (next_st.radio != st.radio) begin
            next_st.csSeen      = 1'b0;
            next_st.symbolCount = 4'h0;
        end

        // Derived outputs, registered so data pins never glitch
        next_st.preambleBytes = preamble_len(st.preambleCfg[PREAMBLE_LSB +: 3]);
        // Word in units of fxosc/2^17
        // Widened before the shift; largest word 15 << 7 still fits eleven bits
        next_st.devWord = {7'h00, DEV_IMPLIED_ONE | {1'b0, devMant}} << devExp;
        next_st.txOffset = 12'h000;
        next_st.rxExpectedDev = 11'h000;
        if (isFsk && st.radio == RMSC_TX) begin
            next_st.txOffset = radioIn.txSymbol ? {1'b0, st.devWord}
                                                : 12'(-{1'b0, st.devWord});
        end
        if (isFsk && st.radio == RMSC_RX) begin
            next_st.rxExpectedDev = st.devWord;
        end
        case (ccaMode)
            CCA_ALWAYS:     next_st.clearChannel = 1'b1;
            CCA_RSSI:       next_st.clearChannel = radioIn.rssiBelow;
            CCA_NOT_RX_PKT: next_st.clearChannel = !radioIn.receivingPacket;
            default:        next_st.clearChannel = radioIn.rssiBelow && !radioIn.receivingPacket;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st              <= '0;
            st.preambleCfg  <= RST_PREAMBLE;
            st.deviation    <= RST_DEVIATION;
            st.rxTimeoutCfg <= RST_RX_TIMEOUT;
            st.nextStateCfg <= RST_NEXT_STATE;
            st.radio        <= RMSC_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign spiMiso       = st.miso;
    assign radioState    = st.radio;
    assign clearChannel  = st.clearChannel;
    assign preambleBytes = st.preambleBytes;
    assign devWord       = st.devWord;
    assign txOffset      = st.txOffset;
    assign rxExpectedDev = st.rxExpectedDev;
endmodule : rmsc_config

// ===== core/rmsc_pkg.sv
// Package: register map, field layout, resets and types of the modem/state config bank
package rmsc_pkg;
    localparam logic [5:0] ADDR_PREAMBLE   = 6'h13;
    localparam logic [5:0] ADDR_DEVIATION  = 6'h15;
    localparam logic [5:0] ADDR_RX_TIMEOUT = 6'h16;
    localparam logic [5:0] ADDR_NEXT_STATE = 6'h17;

    localparam logic [7:0] RST_PREAMBLE   = 8'h22;
    localparam logic [7:0] RST_DEVIATION  = 8'h47;
    localparam logic [7:0] RST_RX_TIMEOUT = 8'h07;
    localparam logic [7:0] RST_NEXT_STATE = 8'h30;

    localparam logic [7:0] WMASK_PREAMBLE   = 8'hF3;
    localparam logic [7:0] WMASK_DEVIATION  = 8'h77;
    localparam logic [7:0] WMASK_RX_TIMEOUT = 8'h1F;
    localparam logic [7:0] WMASK_NEXT_STATE = 8'h3F;

    localparam int PREAMBLE_LSB    = 4;
    localparam int DEV_EXP_LSB     = 4;
    localparam int DEV_MANT_LSB    = 0;
    localparam int RSSI_TERM_BIT   = 4;
    localparam int CLEAR_CHANNEL_MODE_LSB    = 4;
    localparam int AFTER_RX_LSB    = 2;
    localparam int AFTER_TX_LSB    = 0;

    localparam logic [3:0] DEV_IMPLIED_ONE = 4'h8;
    localparam int         DEV_FRAC_BITS   = 17;
    localparam logic [3:0] OOK_TIMEOUT_SYMBOLS = 4'h8;

    localparam logic [4:0] SPI_HEADER_BITS = 5'h08;
    localparam logic [4:0] SPI_FRAME_BITS  = 5'h10;
    localparam int         SPI_READ_BIT    = 7;

    localparam logic [2:0] MOD_2FSK = 3'h0;
    localparam logic [2:0] MOD_GFSK = 3'h1;
    localparam logic [2:0] MOD_OOK  = 3'h3;
    localparam logic [2:0] MOD_4FSK = 3'h4;

    localparam logic [1:0] CCA_ALWAYS      = 2'h0;
    localparam logic [1:0] CCA_RSSI        = 2'h1;
    localparam logic [1:0] CCA_NOT_RX_PKT  = 2'h2;

    typedef enum logic [1:0] {
        RMSC_IDLE  = 2'h0,
        RMSC_RX    = 2'h1,
        RMSC_TX    = 2'h3,
        RMSC_FSTXR = 2'h2
    } rmsc_radio_e;

    typedef struct packed {
        logic startRx;
        logic startTx;
        logic goIdle;
        logic rxPacketDone;
        logic txPacketDone;
        logic carrierSense;
        logic rssiBelow;
        logic receivingPacket;
        logic symbolTick;
        logic txSymbol;
    } rmsc_radio_in_s;

    typedef struct packed {
        logic        sclk;
        logic        csN;
        logic        mosi;
    } rmsc_spi_in_s;

    typedef struct packed {
        logic [7:0]  preambleCfg;
        logic [7:0]  deviation;
        logic [7:0]  rxTimeoutCfg;
        logic [7:0]  nextStateCfg;
        rmsc_radio_e radio;
        logic        sclkPrev;
        logic [4:0]  bitCount;
        logic [7:0]  shiftIn;
        logic [7:0]  shiftOut;
        logic        isRead;
        logic [5:0]  addr;
        logic        miso;
        logic [3:0]  symbolCount;
        logic        csSeen;
        logic [4:0]  preambleBytes;
        logic [10:0] devWord;
        logic [11:0] txOffset;
        logic [10:0] rxExpectedDev;
        logic        clearChannel;
    } rmsc_state_s;
endpackage : rmsc_pkg

// ===== test/rmsc_asserts.sv
// Checker on the config bank ports
`timescale 1ns/1ps
module rmsc_asserts
    import rmsc_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           reset,
    input wire rmsc_spi_in_s   spiIn,
    input wire logic           spiMiso,
    input wire logic [2:0]     modFormat,
    input wire rmsc_radio_in_s radioIn,
    input wire rmsc_radio_e    radioState,
    input wire logic           clearChannel,
    input wire logic [4:0]     preambleBytes,
    input wire logic [10:0]    devWord,
    input wire logic [11:0]    txOffset,
    input wire logic [10:0]    rxExpectedDev
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire fsk = modFormat inside {MOD_2FSK, MOD_GFSK, MOD_4FSK};
    wire inTx = radioState == RMSC_TX;
    wire inRx = radioState == RMSC_RX;
    wire [11:0] dev = {1'b0, devWord};
    function automatic bit devOk(logic [10:0] w);
        devOk = 1'b0;
        for (int e = 0; e < 8; e++) devOk |= w == 11'({1'b1, w[e +: 3]}) << e;
    endfunction : devOk
    reset_vals_a: assert property ($fell(reset) |=> dev == 12'h0F0 && preambleBytes == 5'h04)
        else $error("bad reset outputs");
    dev_form_a: assert property (!$past(reset) |-> devOk(devWord))
        else $error("bad deviation word");
    pre_set_a: assert property (!$past(reset) |-> preambleBytes inside
        {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18}) else $error("bad preamble count");
    tx_offset_a: assert property (inTx && $past(inTx) && fsk && $past(fsk) && $stable(dev) |->
        txOffset == ($past(radioIn.txSymbol) ? dev : 12'h000 - dev)) else $error("bad tx offset");
    rx_expect_a: assert property (inRx && $past(inRx) && fsk && $past(fsk) && $stable(dev) |->
        rxExpectedDev == devWord) else $error("bad rx deviation");
    ook_ignore_a: assert property (modFormat == MOD_OOK && $past(modFormat) == MOD_OOK |->
        txOffset == 12'h000 && rxExpectedDev == 11'h000) else $error("deviation used in OOK");
    idle_zero_a: assert property (radioState == RMSC_IDLE && $past(radioState) == RMSC_IDLE |->
        txOffset == 12'h000 && rxExpectedDev == 11'h000) else $error("offset while idle");
    cca_clear_a: assert property (!$past(reset) && $past(radioIn.rssiBelow && !radioIn.receivingPacket) |->
        clearChannel) else $error("clear channel missing");
    cover property (inTx && fsk);
    cover property (inRx && modFormat == MOD_OOK);
    cover property ($past(inRx) && radioState == RMSC_IDLE);
endmodule : rmsc_asserts
bind rmsc_config rmsc_asserts chk_u (.clk_sys(clk_sys), .reset(reset), .spiIn(spiIn), .spiMiso(spiMiso),
    .modFormat(modFormat), .radioIn(radioIn), .radioState(radioState), .clearChannel(clearChannel),
    .preambleBytes(preambleBytes), .devWord(devWord), .txOffset(txOffset), .rxExpectedDev(rxExpectedDev));

// ===== test/rmsc_config_tb_top.sv
// Testbench for the config bank
`timescale 1ns/1ps
module rmsc_config_tb_top
    import rmsc_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         reset = 1'b1;
    rmsc_spi_in_s spiIn;
    logic         spiMiso;
    logic [2:0]   modFormat = 3'h0;
    logic [9:0]   rin = 10'h000;
    rmsc_radio_e  radioState;
    logic         clearChannel;
    logic [4:0]   preambleBytes;
    logic [10:0]  devWord;
    logic [11:0]  txOffset;
    logic [10:0]  rxExpectedDev;
    logic [7:0]   rd;
    int           errTotal = 0;
    int           numChecks = 0;
    // Address, write, readback, preamble bytes, deviation word
    logic [43:0]  rows [14] = '{44'h13_02_02_02_0F0, 44'h13_12_12_03_0F0, 44'h13_22_22_04_0F0,
        44'h13_32_32_06_0F0, 44'h13_42_42_08_0F0, 44'h13_52_52_0C_0F0, 44'h13_62_62_10_0F0,
        44'h13_FF_F3_18_0F0, 44'h15_12_12_18_014, 44'h15_FF_77_18_780, 44'h15_00_00_18_008,
        44'h16_FF_1F_18_008, 44'h16_07_07_18_008, 44'h20_5A_00_18_008};
    rmsc_radio_e  nxt [4] = '{RMSC_IDLE, RMSC_FSTXR, RMSC_TX, RMSC_RX};
    logic [15:0]  rstTab [4] = '{16'h1322, 16'h1547, 16'h1607, 16'h1730};
    rmsc_config dut_u (.clk_sys(clk_sys), .reset(reset), .spiIn(spiIn), .spiMiso(spiMiso), .modFormat(modFormat),
        .radioIn(rin), .radioState(radioState), .clearChannel(clearChannel), .preambleBytes(preambleBytes),
        .devWord(devWord), .txOffset(txOffset), .rxExpectedDev(rxExpectedDev));
    rmsc_host host_u (.clk_sys(clk_sys), .spiMiso(spiMiso), .spiIn(spiIn));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        if (w) host_u.xfer({2'h0, a[5:0], d}, rd);
        host_u.xfer({2'h2, a[5:0], 8'h00}, rd);
    endtask : acc
    task automatic pulse(input logic [9:0] m);
        rin = rin | m;
        @(negedge clk_sys);
        rin = rin & ~m;
        @(negedge clk_sys);
    endtask : pulse
    task automatic testDone;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : testDone
    initial begin
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        foreach (rows[i]) begin
            acc(rows[i][43:36], rows[i][35:28], 1'b1);
            chk(12'(rd), 12'(rows[i][27:20]));
            chk(12'(preambleBytes), 12'(rows[i][19:12]));
            chk(12'(devWord), rows[i][11:0]);
        end
        $display("table done");
        // Second reset in mid-run; only preamble and deviation hold non-default contents
        reset = 1'b1;
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        foreach (rstTab[i]) begin
            acc(rstTab[i][15:8], 8'h00, 1'b0);
            chk(12'(rd), 12'(rstTab[i][7:0]));
        end
        $display("reset done");
        for (int m = 0; m < 4; m++) begin
            acc(8'h17, 8'(m * 16), 1'b1);
            for (int c = 0; c < 4; c++) begin
                rin[3:2] = 2'(c);
                repeat (2) @(negedge clk_sys);
                chk(12'(clearChannel), 12'(m == 0 || (m == 1 && c[1]) || (m == 2 && !c[0]) || c == 2));
            end
        end
        rin = 10'h000;
        $display("clear channel done");
        for (int r = 0; r < 4; r++) begin
            acc(8'h17, 8'(r * 5), 1'b1);
            pulse(10'h200);
            pulse(10'h040);
            chk(12'(radioState), 12'(nxt[r]));
            pulse(10'h080);
            pulse(10'h100);
            pulse(10'h020);
            chk(12'(radioState), 12'(nxt[r]));
            pulse(10'h080);
        end
        for (int i = 0; i < 5; i++) begin
            modFormat = 3'(i);
            pulse(10'h100);
            rin[0] = 1'b1;
            repeat (2) @(negedge clk_sys);
            chk(txOffset, i == 3 || i == 2 ? 12'h000 : 12'h0F0);
            rin[0] = 1'b0;
            repeat (2) @(negedge clk_sys);
            chk(txOffset, i == 3 || i == 2 ? 12'h000 : 12'hF10);
            pulse(10'h080);
            pulse(10'h200);
            chk(12'(rxExpectedDev), i == 3 || i == 2 ? 12'h000 : 12'h0F0);
            pulse(10'h080);
        end
        $display("next state done");
        acc(8'h16, 8'h17, 1'b1);
        modFormat = MOD_2FSK;
        rin = 10'h010;
        pulse(10'h200);
        @(negedge clk_sys);
        chk(12'(radioState), 12'(RMSC_RX));
        rin[4] = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(12'(radioState), 12'(RMSC_IDLE));
        modFormat = MOD_OOK;
        pulse(10'h200);
        repeat (7) pulse(10'h002);
        chk(12'(radioState), 12'(RMSC_RX));
        pulse(10'h002);
        chk(12'(radioState), 12'(RMSC_IDLE));
        pulse(10'h200);
        pulse(10'h010);
        repeat (8) pulse(10'h002);
        chk(12'(radioState), 12'(RMSC_RX));
        $display("termination done");
        testDone;
    end
endmodule : rmsc_config_tb_top

// ===== test/rmsc_host.sv
// Host model: serial port master, mode 0, MSB first
`timescale 1ns/1ps
module rmsc_host
    import rmsc_pkg::*;
(
    input wire logic     clk_sys,
    input wire logic     spiMiso,
    output rmsc_spi_in_s spiIn
);
    initial begin
        spiIn = 3'h2;
    end
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        spiIn.csN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiIn.mosi = frame[i];
            // Extra low cycle so the answer bit has surely settled
            repeat (3) @(negedge clk_sys);
            rd = {rd[6:0], spiMiso};
            spiIn.sclk = 1'b1;
            repeat (2) @(negedge clk_sys);
            spiIn.sclk = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
        // Released data line flips so a stale level cannot pass
        spiIn = {1'b0, 1'b1, ~spiIn.mosi};
        repeat (2) @(negedge clk_sys);
    endtask : xfer
endmodule : rmsc_host
